// ===== hw/flash_host_pkg.sv
package flash_host_pkg;

    // array shape
    localparam int unsigned PAGES_PER_BLOCK  = 64;
    localparam int unsigned MAIN_BYTES       = 2048;
    localparam int unsigned SPARE_BYTES      = 64;
    localparam int unsigned MAIN_WORDS       = 1024;
    localparam int unsigned SPARE_WORDS      = 32;
    localparam int unsigned GOOD_BLOCKS_2G   = 2008;
    localparam int unsigned GOOD_BLOCKS_1G   = 1004;
    localparam int unsigned ADDR_CYCLES_1G   = 4;
    localparam int unsigned ADDR_CYCLES_2G   = 5;

    // timing
    localparam int unsigned CLK_MHZ          = 40;
    localparam int unsigned RECOVERY_US      = 10;
    localparam int unsigned RECOVERY_CYCLES  = RECOVERY_US * CLK_MHZ;
    localparam int unsigned GLITCH_NS        = 5;
    localparam int unsigned CLK_NS           = 25;
    // strobe half-phase length: at least a glitch width, at least one cycle
    localparam int unsigned STROBE_CYCLES    = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;

    // fifo
    localparam int unsigned FIFO_DEPTH       = 32;
    localparam int unsigned DATA_W           = 16;

    // host command kinds
    typedef enum logic [1:0] {
        OP_CMD,
        OP_ADDR,
        OP_WRITE,
        OP_READ
    } op_kind_t;

endpackage : flash_host_pkg

// ===== hw/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push;
    wire              pop;

    // full and empty from pointer compare
    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end

    no_overflow_a: assert property (@(posedge clk) disable iff (reset)
        (wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");

endmodule : word_fifo

// ===== hw/strobe_timer.sv
`timescale 1ns/100ps
module strobe_timer #(
    parameter int unsigned WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_q;

    // down counter; done while at zero
    assign done = cnt_q == '0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule : strobe_timer

// ===== hw/flash_host.sv
// How it works
// - host software tolerates bad blocks; at least 2008 or 1004 good
// - no command before 10 us after power-up; hold write strobe high
// - host holds write protect low during power ramps
// - shared wired ready busy low means some device busy
// - command cycle: select low, cmd latch high, addr latch low, read high
// - four address cycles for 1 Gb, five for 2 Gb
// - address cycle: select low, addr latch high, cmd latch low, read high
// - data input: both latches low, read high, one word per write
// - data output: write high, both latches low, read strobes sequence data
`timescale 1ns/100ps
module flash_host (
    input  wire logic                          clk,
    input  wire logic                          reset,
    // user command port
    input  wire flash_host_pkg::op_kind_t      req_kind,
    input  wire logic [flash_host_pkg::DATA_W-1:0] req_data,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          wide_bus,
    input  wire logic                          prog_enable,
    // read data out
    output logic [flash_host_pkg::DATA_W-1:0]  rd_data,
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output logic                               flash_busy,
    output logic                               power_ok,
    // flash pins
    output logic                               chip_sel_n,
    output logic                               cmd_latch_en,
    output logic                               addr_latch_en,
    output logic                               write_n,
    output logic                               read_n,
    output logic                               write_prot_n,
    output logic [7:0]                         low_byte_lane_o,
    output logic                               low_byte_lane_oe,
    input  wire logic [7:0]                    low_byte_lane_i,
    output logic [7:0]                         high_byte_lane_o,
    output logic                               high_byte_lane_oe,
    input  wire logic [7:0]                    high_byte_lane_i,
    input  wire logic                          ready_busy_n
);
    import flash_host_pkg::*;

    localparam int unsigned TW = 9;
    localparam logic [TW-1:0] T_RECOVER = TW'(RECOVERY_CYCLES);
    localparam logic [TW-1:0] T_STROBE  = TW'(STROBE_CYCLES);

    typedef enum logic [2:0] {
        ST_POWER,
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_CAPTURE
    } state_t;

    state_t            state_q;
    state_t            state_d;
    op_kind_t          kind_q;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] rd_word_q;
    logic              rd_push_q;
    logic              power_ok_q;
    logic              busy_s1_q;
    logic              busy_q;
    logic              wp_n_q;
    logic              cs_n_q;
    logic              cle_q;
    logic              ale_q;
    logic              we_n_q;
    logic              re_n_q;
    logic              lo_oe_q;
    logic              hi_oe_q;
    logic [7:0]        lo_o_q;
    logic [7:0]        hi_o_q;
    logic              timer_load;
    logic [TW-1:0]     timer_count;
    logic              timer_done;
    logic              fifo_in_ready;
    logic              boot_q;

    // timer for power recovery and strobe phases
    strobe_timer #(.WIDTH(TW)) u_timer (
        .clk   (clk),
        .reset (reset),
        .load  (timer_load),
        .count (timer_count),
        .done  (timer_done)
    );

    // read words buffered toward the user; full fifo stalls reads
    word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (rd_word_q),
        .in_valid  (rd_push_q),
        .in_ready  (fifo_in_ready),
        .out_data  (rd_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready)
    );

    // decode of the current request; bad block bookkeeping stays with user software
    wire is_read    = req_kind == OP_READ;
    wire room_ok    = !is_read || fifo_in_ready;
    wire take_req   = state_q == ST_IDLE && req_valid && room_ok;
    wire start_low  = state_q == ST_POWER && timer_done;
    wire phase_done = timer_done; // reload only comes from the state decode
    wire word_read  = kind_q == OP_READ;
    wire lane_hi_en = wide_bus && (kind_q == OP_WRITE);
    // data writes only when protection released by software and power good
    wire wp_release = prog_enable && power_ok_q;

    // next state
    always_comb begin
        state_d     = state_q;
        timer_load  = 1'b0;
        timer_count = T_STROBE;
        case (state_q)
            ST_POWER: begin
                if (boot_q) begin
                    timer_load  = 1'b1;
                    timer_count = T_RECOVER;
                end else if (timer_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (take_req) begin
                    state_d    = ST_LOW;
                    timer_load = 1'b1;
                end
            end
            ST_LOW: begin
                if (phase_done) begin
                    state_d    = ST_HIGH;
                    timer_load = 1'b1;
                end
            end
            ST_HIGH: begin
                if (phase_done) state_d = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // power-up recovery load on first cycle after reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) boot_q <= 1'b1;
        else       boot_q <= 1'b0;
    end

    // state and request capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_POWER;
            kind_q  <= OP_CMD;
            data_q  <= '0;
        end else begin
            state_q <= state_d;
            if (take_req) begin
                kind_q <= req_kind;
                data_q <= req_data;
            end
        end
    end

    // delayed boot pulse keeps power good off while the timer loads
    logic rec_load_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) rec_load_q <= 1'b0;
        else       rec_load_q <= boot_q;
    end

    // power good flag after recovery
    always_ff @(posedge clk or posedge reset) begin
        if (reset)                           power_ok_q <= 1'b0;
        else if (start_low && !rec_load_q && !boot_q) power_ok_q <= 1'b1;
    end

    // ready busy level: two flops, wired low means any device busy
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_s1_q <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            busy_s1_q <= !ready_busy_n;
            busy_q    <= busy_s1_q;
        end
    end

    // pin drive: control strobes by cycle kind
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_n_q  <= 1'b1;
            cle_q   <= 1'b0;
            ale_q   <= 1'b0;
            we_n_q  <= 1'b1;
            re_n_q  <= 1'b1;
            wp_n_q  <= 1'b0;
        end else begin
            wp_n_q <= wp_release;
            if (take_req) begin
                cs_n_q <= 1'b0;
                cle_q  <= req_kind == OP_CMD;
                ale_q  <= req_kind == OP_ADDR;
                we_n_q <= is_read;
                re_n_q <= !is_read;
            end else if (state_q == ST_LOW && phase_done) begin
                we_n_q <= 1'b1;
                re_n_q <= 1'b1;
            end else if (state_q == ST_CAPTURE) begin
                cs_n_q <= 1'b1;
                cle_q  <= 1'b0;
                ale_q  <= 1'b0;
            end
        end
    end

    // lane drive: low lane for all writes, high lane only for wide data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lo_o_q  <= '0;
            hi_o_q  <= '0;
            lo_oe_q <= 1'b0;
            hi_oe_q <= 1'b0;
        end else if (take_req) begin
            lo_o_q  <= req_data[7:0];
            hi_o_q  <= req_data[15:8];
            lo_oe_q <= !is_read;
            hi_oe_q <= !is_read && wide_bus && req_kind == OP_WRITE;
        end else if (state_q == ST_CAPTURE) begin
            lo_oe_q <= 1'b0;
            hi_oe_q <= 1'b0;
        end
    end

    // read sample at end of read-low phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_word_q <= '0;
            rd_push_q <= 1'b0;
        end else begin
            rd_push_q <= state_q == ST_LOW && phase_done && word_read;
            if (state_q == ST_LOW && phase_done && word_read) begin
                rd_word_q <= {wide_bus ? high_byte_lane_i : 8'h00, low_byte_lane_i};
            end
        end
    end

    // user handshake
    always_ff @(posedge clk or posedge reset) begin
        if (reset) req_ready <= 1'b0;
        else       req_ready <= state_d == ST_IDLE && state_q != ST_IDLE;
    end

    assign chip_sel_n        = cs_n_q;
    assign cmd_latch_en      = cle_q;
    assign addr_latch_en     = ale_q;
    assign write_n           = we_n_q;
    assign read_n            = re_n_q;
    assign write_prot_n      = wp_n_q;
    assign low_byte_lane_o   = lo_o_q;
    assign low_byte_lane_oe  = lo_oe_q;
    assign high_byte_lane_o  = hi_o_q;
    assign high_byte_lane_oe = hi_oe_q;
    assign flash_busy        = busy_q;
    assign power_ok          = power_ok_q;

    // high lane only ever driven during a wide data write
    hi_data_a: assert property (@(posedge clk) disable iff (reset)
        hi_oe_q |-> lane_hi_en) else $error("high lane driven outside wide write");

    no_write_early_a: assert property (@(posedge clk) disable iff (reset)
        !power_ok_q |-> write_n) else $error("write strobe low before recovery");
    cmd_cycle_a: assert property (@(posedge clk) disable iff (reset)
        (cle_q && !we_n_q) |-> (!cs_n_q && !ale_q && re_n_q)) else $error("bad command cycle");
    addr_cycle_a: assert property (@(posedge clk) disable iff (reset)
        (ale_q && !we_n_q) |-> (!cs_n_q && !cle_q && re_n_q)) else $error("bad address cycle");
    read_cycle_a: assert property (@(posedge clk) disable iff (reset)
        !re_n_q |-> (we_n_q && !cle_q && !ale_q && !lo_oe_q)) else $error("bad read cycle");
    strobe_width_a: assert property (@(posedge clk) disable iff (reset)
        $fell(we_n_q) |-> !we_n_q [*2]) else $error("write strobe too short");
    wp_power_a: assert property (@(posedge clk) disable iff (reset)
        !power_ok_q |-> !wp_n_q) else $error("protect released during power ramp");
    hi_lane_a: assert property (@(posedge clk) disable iff (reset)
        (cle_q || ale_q) |-> !hi_oe_q) else $error("high lane driven on cmd or addr");
    busy_sync_a: assert property (@(posedge clk) disable iff (reset)
        !ready_busy_n |-> ##2 flash_busy) else $error("busy not followed");

endmodule : flash_host

// ===== tb/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model (
    input  wire logic        chip_sel_n,
    input  wire logic        cmd_latch_en,
    input  wire logic        addr_latch_en,
    input  wire logic        write_n,
    input  wire logic        read_n,
    input  wire logic        write_prot_n,
    input  wire logic [15:0] host_lane,
    input  wire logic        busy_in,
    output logic      [15:0] dev_lane,
    output logic             pull_low
);
    logic [15:0] mem [0:63];
    realtime     wr_fall;
    logic [7:0]  abuf [0:4];
    logic [7:0]  last_cmd;
    logic [15:0] rword;
    int          acnt;
    int          wr_ptr;
    int          rd_ptr;
    int          bad;
    // page preset with a pattern the bench can predict
    initial begin
        rword = 16'h0000;
        for (int i = 0; i < 64; i++)
            mem[i] = {8'(i) ^ 8'h5a, 8'(i) + 8'h11};
    end
    // remember the falling write strobe to measure its low width
    always @(negedge write_n) wr_fall = $realtime;
    // latch on the rising write strobe while selected; short pulses count as bad
    always @(posedge write_n) begin
        if (!chip_sel_n && (!read_n || (cmd_latch_en && addr_latch_en) ||
            ($realtime - wr_fall < 5.0))) begin
            bad++;
        end else if (!chip_sel_n && cmd_latch_en) begin
            last_cmd = host_lane[7:0];
            acnt = 0;
            wr_ptr = 0;
            rd_ptr = 0;
        end else if (!chip_sel_n && addr_latch_en) begin
            if (acnt < 5)
                abuf[acnt] = host_lane[7:0];
            acnt++;
        end else if (!chip_sel_n && write_prot_n) begin
            mem[wr_ptr] = host_lane;
            wr_ptr++;
        end
    end
    // each falling read strobe fetches the next column
    always @(negedge read_n) begin
        if (!chip_sel_n) begin
            rword = mem[rd_ptr];
            rd_ptr++;
        end
    end
    // undriven lanes show garbage, not the last word
    assign dev_lane = (!chip_sel_n && !read_n) ? rword : ~rword;
    assign pull_low = busy_in;
endmodule : flash_dev_model

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
    import flash_host_pkg::*;
    op_kind_t    req_kind;
    logic [15:0] req_data, rd_data, dev_lane;
    logic        clk, reset, req_valid, req_ready, wide_bus, prog_enable;
    logic        rd_valid, rd_ready, flash_busy, power_ok, chip_sel_n;
    logic        cmd_latch_en, addr_latch_en, write_n, read_n, write_prot_n;
    logic [7:0]  low_byte_lane_o, low_byte_lane_i, high_byte_lane_o, high_byte_lane_i;
    logic        low_byte_lane_oe, high_byte_lane_oe, ready_busy_n;
    logic        pull_low, dev_busy, other_busy;
    int          fail_count, checked;

    flash_host flash_host_i (.clk, .reset, .req_kind, .req_data, .req_valid, .req_ready,
        .wide_bus, .prog_enable, .rd_data, .rd_valid, .rd_ready, .flash_busy, .power_ok,
        .chip_sel_n, .cmd_latch_en, .addr_latch_en, .write_n, .read_n, .write_prot_n,
        .low_byte_lane_o, .low_byte_lane_oe, .low_byte_lane_i, .high_byte_lane_o,
        .high_byte_lane_oe, .high_byte_lane_i, .ready_busy_n);
    flash_dev_model flash_dev_model_i (.chip_sel_n, .cmd_latch_en, .addr_latch_en,
        .write_n, .read_n, .write_prot_n, .host_lane({high_byte_lane_o, low_byte_lane_o}),
        .busy_in(dev_busy), .dev_lane, .pull_low);

    // lane and wired ready line resolution
    assign low_byte_lane_i = low_byte_lane_oe ? low_byte_lane_o : dev_lane[7:0];
    assign high_byte_lane_i = high_byte_lane_oe ? high_byte_lane_o : dev_lane[15:8];
    assign ready_busy_n = !(pull_low || other_busy);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    // one bus cycle: wait for the strobe phase, check pins, wait for completion
    task automatic op(input op_kind_t k, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_kind <= k;
        req_data <= d;
        req_valid <= 1'b1;
        while (chip_sel_n !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(cmd_latch_en === (k == OP_CMD) && addr_latch_en === (k == OP_ADDR) &&
            read_n === (k != OP_READ) && write_n === (k == OP_READ), "strobe pins");
        chk(low_byte_lane_oe === (k != OP_READ) &&
            high_byte_lane_oe === (k == OP_WRITE && wide_bus), "lane drive");
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk(n < 50 && chip_sel_n === 1'b1 && low_byte_lane_oe === 1'b0, "cycle end");
    endtask : op

    task automatic t_power;
        int n;
        n = 0;
        while (power_ok !== 1'b1 && n < 600) begin
            @(negedge clk);
            chk(write_n === 1'b1 && write_prot_n === 1'b0, "recovery pins");
            n++;
        end
        chk(n >= RECOVERY_CYCLES && n <= RECOVERY_CYCLES + 20, "recovery length");
    endtask : t_power

    task automatic t_cmd_addr;
        op(OP_CMD, 16'h0080);
        chk(flash_dev_model_i.last_cmd === 8'h80, "command byte");
        for (int i = 0; i < ADDR_CYCLES_2G; i++)
            op(OP_ADDR, {8'hff, 8'(i * 19 + 7)});
        chk(flash_dev_model_i.acnt == ADDR_CYCLES_2G, "address count");
        for (int i = 0; i < ADDR_CYCLES_2G; i++)
            chk(flash_dev_model_i.abuf[i] === 8'(i * 19 + 7), "address order");
    endtask : t_cmd_addr

    task automatic t_busy;
        @(posedge clk);
        dev_busy <= 1'b1;
        repeat (4) @(negedge clk);
        chk(flash_busy === 1'b1, "busy seen");
        @(posedge clk);
        dev_busy <= 1'b0;
        other_busy <= 1'b1;
        repeat (4) @(negedge clk);
        chk(flash_busy === 1'b1, "shared busy");
        @(posedge clk);
        other_busy <= 1'b0;
        repeat (4) @(negedge clk);
        chk(flash_busy === 1'b0, "ready seen");
    endtask : t_busy

    // fill the fifo, see the next read held off, drain in order
    task automatic t_read_fifo;
        int n;
        op(OP_CMD, 16'h0000);
        for (int i = 0; i < FIFO_DEPTH; i++)
            op(OP_READ, 16'h0000);
        fork
            op(OP_READ, 16'h0000);
            begin
                repeat (30) @(negedge clk);
                chk(chip_sel_n === 1'b1, "read while full");
                @(posedge clk);
                rd_ready <= 1'b1;
                for (int i = 0; i <= FIFO_DEPTH; i++) begin
                    n = 0;
                    @(negedge clk);
                    while (rd_valid !== 1'b1 && n < 50) begin
                        @(negedge clk);
                        n++;
                    end
                    chk(rd_data === {8'h00, 8'(i) + 8'h11}, "read order");
                end
            end
        join
    endtask : t_read_fifo

    task automatic t_write;
        @(posedge clk);
        prog_enable <= 1'b1;
        wide_bus <= 1'b1;
        op(OP_CMD, 16'h0080);
        op(OP_WRITE, 16'hbeef);
        op(OP_WRITE, 16'h1234);
        chk(flash_dev_model_i.mem[0] === 16'hbeef, "wide word 0");
        chk(flash_dev_model_i.mem[1] === 16'h1234, "wide word 1");
        @(posedge clk);
        prog_enable <= 1'b0;
        repeat (3) @(negedge clk);
        chk(write_prot_n === 1'b0, "protect level");
        op(OP_WRITE, 16'h5555);
        chk(flash_dev_model_i.mem[2] === {8'h58, 8'h13}, "protected word");
    endtask : t_write

    task automatic test_done;
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_kind = OP_CMD;
        req_data = 16'h0000;
        wide_bus = 1'b0;
        prog_enable = 1'b0;
        rd_ready = 1'b0;
        dev_busy = 1'b0;
        other_busy = 1'b0;
        repeat (10) @(posedge clk);
        chk(chip_sel_n === 1'b1 && write_prot_n === 1'b0, "reset pins");
        reset <= 1'b0;
        t_power;
        t_cmd_addr;
        t_busy;
        t_read_fifo;
        t_write;
        chk(flash_dev_model_i.bad == 0, "strobe framing");
        test_done;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end
endmodule : tb
